// ### mode_ctrl_params.svh
// Purpose: offset, code, count and reset-value constants of the mode block
// Assumes: included by the package and by the mode block
// Notes: byte addresses on the plain register port, 12-bit wide
`ifndef MODE_CTRL_PARAMS_SVH
`define MODE_CTRL_PARAMS_SVH

// register port layout
`define ADDR_W 12
`define OFS_STATUS 12'h000
`define OFS_COUNTER 12'h004
`define OFS_PIN_TRY 12'h008
`define OFS_PIN_NEW 12'h00c
`define OFS_LOCK 12'h010
`define OFS_MODE 12'h014
`define OFS_CFG_BASE 12'h100
`define OFS_USER_BASE 12'h200
`define PAGE_BYTES 4
`define PAGE_SHIFT 2
`define CFG_PAGES 16
`define USER_PAGES 16
`define PAGE_IDX_W 4

// reset and factory values
`define PIN_DEFAULT 32'h000e215
`define COUNTER_INIT 24'h000000
`define PAGE_INIT 32'h00000000

// frame codes
`define TYPE_RED_PRESS 8'h05
`define TYPE_RED_RELEASE 8'h06
`define TYPE_ROCKER 8'hf6
`define TYPE_RED_SECURE 8'h7f
`define TYPE_SECURE 8'h30
`define ID_EXT_MSB 8'hfe
`define LEN_RED_NORMAL 4'h6
`define LEN_ROCKER 4'h8
`define ADDR_CTL_ORIG32 3'b001
`define EXT_HDR_NONE 1'b0
`define TTYPE_ROCKER 4'b0000
`define TTYPE_SECURE 4'b0111

// redundancy and sequence counts
`define REP_NORMAL 2'h3
`define REP_SECURE 2'h2
`define REP_TEACH 2'h1
`define TEACH_PRESS 3'h2
`define RESET_CYCLES 3'h7

`endif

// ### mode_ctrl_pkg.sv
// Purpose: types shared by the mode block and its environment
// Assumes: mode_ctrl_params.svh holds every number
// Notes: enum codes left to the tool
`default_nettype none
`include "mode_ctrl_params.svh"
package mode_ctrl_pkg;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_SEC_IMPL, MODE_SEC_EXPL} mode_e;
  typedef enum logic [1:0] {CHORD_NONE, CHORD_TWO, CHORD_THREE,
                            CHORD_FOUR} chord_e;
  typedef enum logic [1:0] {TEL_DATA, TEL_TEACH1, TEL_TEACH2} tel_kind_e;
  typedef enum logic {SEQ_IDLE, SEQ_ACTIVE} seq_e;

  // one telegram request towards the radio
  typedef struct packed {
    logic valid;
    tel_kind_e kind;
    logic second;
    logic reduced;
    logic [7:0] frame_type;
    logic [7:0] header;
    logic [3:0] length;
    logic [1:0] repeats;
    logic rocker;
    logic [23:0] counter;
    logic [7:0] data;
    logic [31:0] transmitter_identifier;
    logic [3:0] check;
    logic opt_data;
    logic [7:0] exp_type;
    logic [7:0] exp_id_msb;
  } tel_s;

  // whole state of the mode block
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic bow_prev;
    mode_e mode;
    logic unlocked;
    logic [31:0] pin;
    seq_e seq;
    chord_e chord;
    logic rocker;
    logic [2:0] count;
    logic teach2_pend;
    logic teach2_now;
    logic [23:0] counter;
    logic [`CFG_PAGES-1:0][31:0] cfg;
    logic [`USER_PAGES-1:0][31:0] user;
    logic [31:0] rdata;
    tel_s tel;
    logic freset;
  } state_s;

endpackage
`default_nettype wire

// ### mode_ctrl.sv
// Purpose: chord and bow sequence decoding, telegram framing, pin lock
// Assumes: contacts, bow and protocol select come from pins, unsynchronised
// Notes: one telegram request per cycle; the radio does timing and crypto
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_params.svh"

// Overview of operation
// - one full channel pair selects implicit secure
// - any three contacts select explicit secure
// - four contacts, first press selects normal
// - three chord tap teaches if already explicit
// - second press switches mode, sends teach one
// - following release always sends teach two
// - four chord, seven taps start factory reset
// - factory reset keeps the user pages and the counter
// - first protocol frame choice follows mode
// - reduced normal frame is six bytes
// - reduced normal type five or six
// - reduced frames carry four-bit check
// - reduced secure frame type 0x7f, expands 0x30
// - expanded secure id gains 0xfe msb
// - explicit counter uses encrypted rocker frame
// - second protocol normal header 001, 0, 0000
// - second protocol secure header type 0111
// - second protocol never sends optional data
// - normal sent three times, secure twice
// - config locked until 32-bit pin matches
// - config memory addressed in four-byte pages
// - counter starts zero, counts every telegram
// - teach rocker names fully pressed pair
module mode_ctrl
  import mode_ctrl_pkg::*;
#(
  parameter logic [31:0] TX_ID = 32'h00000001 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic a_upper,
  input wire logic a_lower,
  input wire logic b_upper,
  input wire logic b_lower,
  input wire logic bow,
  input wire logic proto_second,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output tel_s tel,
  output mode_e mode,
  output logic unlocked,
  output logic freset
);

  state_s q;
  state_s nxt_q;

  // chord class of the four contacts {a_up, a_lo, b_up, b_lo}
  // two contacts of different channels match no chord at all
  function automatic chord_e classify(input logic [3:0] c);
    logic [2:0] n;
    n = 3'({2'h0, c[3]} + {2'h0, c[2]} + {2'h0, c[1]} + {2'h0, c[0]});
    if (n == 3'h4) begin
      classify = CHORD_FOUR;
    end else if (n == 3'h3) begin
      classify = CHORD_THREE;
    end else if (c == 4'hc || c == 4'h3) begin
      classify = CHORD_TWO;
    end else begin
      classify = CHORD_NONE;
    end
  endfunction

  // nibble sum over the frame type, data and identifier
  // a plain sum is cheap in gates but only catches single nibble errors
  function automatic logic [3:0] nib_sum(input logic [7:0] t,
                                         input logic [7:0] d,
                                         input logic [31:0] id);
    logic [3:0] s;
    s = t[7:4] + t[3:0] + d[7:4] + d[3:0];
    for (int i = 0; i < 8; i++) begin
      s = s + id[i*4 +: 4];
    end
    nib_sum = s;
  endfunction

  // format one telegram from mode, protocol and switch state
  function automatic tel_s build(input tel_kind_e kind, input mode_e m,
                                 input logic second, input logic pressed,
                                 input logic [3:0] c, input logic rk,
                                 input logic [23:0] cnt);
    tel_s t;
    t = '0;
    t.valid = 1'b1;
    t.kind = kind;
    t.second = second;
    t.rocker = rk;
    t.counter = cnt;
    t.data = {3'h0, pressed, c};
    t.transmitter_identifier = TX_ID;
    t.opt_data = 1'b0;
    if (kind != TEL_DATA) begin
      t.repeats = `REP_TEACH; // teach parts are too long for redundancy
    end else if (m == MODE_NORMAL) begin
      t.repeats = `REP_NORMAL;
    end else begin
      t.repeats = `REP_SECURE;
    end
    // the second protocol has no reduced frames, only the header differs
    if (second) begin
      t.reduced = 1'b0;
      if (m == MODE_NORMAL && kind == TEL_DATA) begin
        t.frame_type = `TYPE_ROCKER;
        t.header = {`ADDR_CTL_ORIG32, `EXT_HDR_NONE, `TTYPE_ROCKER};
      end else begin
        t.frame_type = `TYPE_SECURE;
        t.header = {`ADDR_CTL_ORIG32, `EXT_HDR_NONE, `TTYPE_SECURE};
      end
      t.exp_type = t.frame_type;
    end else if (kind != TEL_DATA || m == MODE_SEC_EXPL) begin
      // explicit counter needs the full encrypted rocker frame
      t.reduced = 1'b0;
      t.frame_type = `TYPE_SECURE;
      t.exp_type = `TYPE_SECURE;
    end else if (m == MODE_SEC_IMPL) begin
      t.reduced = 1'b1;
      t.frame_type = `TYPE_RED_SECURE;
      t.exp_type = `TYPE_SECURE;
      t.exp_id_msb = `ID_EXT_MSB;
    end else begin
      t.reduced = 1'b1;
      t.length = `LEN_RED_NORMAL;
      t.frame_type = pressed ? `TYPE_RED_PRESS : `TYPE_RED_RELEASE;
      t.exp_type = `TYPE_ROCKER;
    end
    if (t.reduced) begin
      t.check = nib_sum(t.frame_type, t.data, TX_ID);
    end
    build = t;
  endfunction

  logic press;
  logic release_e;
  logic [3:0] cont;
  logic proto2;
  chord_e ch;
  logic rk_now;
  logic page_cfg;
  logic page_user;
  logic [`PAGE_IDX_W-1:0] page;

  // address split: byte lanes, page index, then the area above both
  localparam int AREA_LSB = `PAGE_SHIFT + `PAGE_IDX_W;
  localparam int AREA_W = `ADDR_W - AREA_LSB;
  logic [AREA_W-1:0] area;
  logic [AREA_W-1:0] cfg_area;
  logic [AREA_W-1:0] user_area;
  logic [31:0] status_word;

  // decoded inputs from the second synchroniser stage only
  assign press = q.sync2[4] & ~q.bow_prev;
  assign release_e = ~q.sync2[4] & q.bow_prev;
  assign cont = q.sync2[3:0];
  assign proto2 = q.sync2[5];
  assign ch = classify(cont);
  assign rk_now = (cont[3:2] == 2'b11) ? 1'b0 : 1'b1;

  // page decode: a page is the smallest unit, low address bits ignored;
  // there are no byte lanes, so software always moves whole pages
  assign page = addr[`PAGE_SHIFT +: `PAGE_IDX_W];

  // area decode above the page index; the shifted base offsets are cut
  // to the area width on purpose, their upper bits are known zero
  assign area = addr[`ADDR_W-1:AREA_LSB];
  assign cfg_area = AREA_W'(`OFS_CFG_BASE >> AREA_LSB);
  assign user_area = AREA_W'(`OFS_USER_BASE >> AREA_LSB);
  assign page_cfg = (area == cfg_area);
  assign page_user = (area == user_area);

  // status word; bit 3 is spare and reads zero like the upper bits
  assign status_word = {23'h000000, q.teach2_pend, q.count, proto2, 1'b0,
                        q.unlocked, q.mode};

  // next-state logic: sequences, telegrams, then register port
  always_comb begin
    logic [2:0] cnt;
    cnt = 3'h1;
    nxt_q = q;
    nxt_q.tel.valid = 1'b0;
    nxt_q.freset = 1'b0;
    nxt_q.teach2_now = 1'b0;
    nxt_q.sync1 = {proto_second, bow, a_upper, a_lower, b_upper, b_lower};
    nxt_q.sync2 = q.sync1;
    nxt_q.bow_prev = q.sync2[4];

    // a bow edge decoded in this cycle is lost; a hand cannot tap twice
    // within one clock, so the simpler priority costs nothing in use
    if (q.teach2_now) begin
      // second half of a tap-triggered teach-in
      nxt_q.tel = build(TEL_TEACH2, q.mode, proto2, 1'b0, cont, q.rocker,
                        q.counter);
    end else if (press) begin
      if (q.seq == SEQ_ACTIVE && ch == q.chord) begin
        cnt = q.count + 3'h1;
      end
      if (ch == CHORD_NONE) begin
        nxt_q.seq = SEQ_IDLE;
        nxt_q.teach2_pend = 1'b0;
        nxt_q.tel = build(TEL_DATA, q.mode, proto2, 1'b1, cont, rk_now,
                          q.counter);
      end else begin
        nxt_q.seq = SEQ_ACTIVE;
        nxt_q.chord = ch;
        nxt_q.count = cnt;
        nxt_q.rocker = rk_now;
        // count is three bits: an eighth press of one chord wraps to zero,
        // matches no entry and so leaves the mode alone
        if (ch == CHORD_FOUR && cnt == 3'h1) begin
          nxt_q.mode = MODE_NORMAL;
        end else if (ch != CHORD_FOUR && cnt == `TEACH_PRESS) begin
          // mode follows the chord, then first teach part
          nxt_q.mode = (ch == CHORD_TWO) ? MODE_SEC_IMPL : MODE_SEC_EXPL;
          nxt_q.tel = build(TEL_TEACH1, nxt_q.mode, proto2, 1'b1, cont,
                            rk_now, q.counter);
          nxt_q.teach2_pend = 1'b1;
        end
      end
    end else if (release_e) begin
      if (q.teach2_pend) begin
        // contacts at this release do not matter
        nxt_q.tel = build(TEL_TEACH2, q.mode, proto2, 1'b0, cont, q.rocker,
                          q.counter);
        nxt_q.teach2_pend = 1'b0;
        nxt_q.seq = SEQ_IDLE;
      end else if (q.seq == SEQ_ACTIVE && ch != q.chord) begin
        nxt_q.seq = SEQ_IDLE; // chord let go mid-sequence
      end else if (q.seq == SEQ_ACTIVE && q.chord == CHORD_THREE &&
                   q.count == 3'h1) begin
        if (q.mode == MODE_SEC_EXPL) begin
          // teach only when explicit secure is already set
          nxt_q.tel = build(TEL_TEACH1, q.mode, proto2, 1'b0, cont, q.rocker,
                            q.counter);
          nxt_q.teach2_now = 1'b1;
        end
      end else if (q.seq == SEQ_ACTIVE && q.chord == CHORD_FOUR &&
                   q.count == `RESET_CYCLES) begin
        // factory defaults; user pages and counter kept
        nxt_q.freset = 1'b1;
        nxt_q.seq = SEQ_IDLE;
        nxt_q.mode = MODE_NORMAL;
        nxt_q.pin = `PIN_DEFAULT;
        nxt_q.unlocked = 1'b0;
        for (int i = 0; i < `CFG_PAGES; i++) begin
          nxt_q.cfg[i] = `PAGE_INIT;
        end
      end else if (q.seq == SEQ_IDLE) begin
        nxt_q.tel = build(TEL_DATA, q.mode, proto2, 1'b0, cont, rk_now,
                          q.counter);
      end
    end

    // every telegram handed to the radio advances the counter
    // 24 bits wrap silently; a lifetime of taps stays far below that
    if (nxt_q.tel.valid) begin
      nxt_q.counter = q.counter + 24'h000001;
    end

    // register writes; one landing with a factory reset is dropped so
    // the restored defaults cannot be overwritten in the same cycle
    if (wr && !nxt_q.freset) begin
      unique case (1'b1)
        addr == `OFS_PIN_TRY: nxt_q.unlocked = (wdata == q.pin);
        addr == `OFS_PIN_NEW: begin
          if (q.unlocked) begin
            nxt_q.pin = wdata;
          end
        end
        addr == `OFS_LOCK: nxt_q.unlocked = 1'b0;
        addr == `OFS_MODE: begin
          // mode change over the port only after unlock
          if (q.unlocked && wdata[1:0] != 2'h3) begin
            nxt_q.mode = mode_e'(wdata[1:0]);
          end
        end
        page_cfg: begin
          if (q.unlocked) begin
            nxt_q.cfg[page] = wdata;
          end
        end
        page_user: nxt_q.user[page] = wdata;
        default: ;
      endcase
    end

    // register reads, answer in the following cycle only
    nxt_q.rdata = 32'h00000000;
    if (rd) begin
      unique case (1'b1)
        addr == `OFS_STATUS: nxt_q.rdata = status_word;
        addr == `OFS_COUNTER: nxt_q.rdata = {8'h00, q.counter};
        page_cfg: begin
          if (q.unlocked) begin
            nxt_q.rdata = q.cfg[page];
          end
        end
        page_user: nxt_q.rdata = q.user[page];
        default: nxt_q.rdata = 32'h00000000;
      endcase
    end

    // frozen while the clock enable is low; placed last so that nothing
    // above, the synchronisers included, can slip past it
    if (!ce) begin
      nxt_q = q;
    end
  end

  // single state register; resets to constants only
  // the struct is cleared first, then mode, seq, chord, pin and counter get their named defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= MODE_NORMAL;
      q.seq <= SEQ_IDLE;
      q.chord <= CHORD_NONE;
      q.pin <= `PIN_DEFAULT;
      q.counter <= `COUNTER_INIT;
    end else begin
      q <= nxt_q;
    end
  end

  // outputs straight from the state register
  assign rdata = q.rdata;
  assign tel = q.tel;
  assign mode = q.mode;
  assign unlocked = q.unlocked;
  assign freset = q.freset;

endmodule // mode_ctrl
`default_nettype wire

// ### mode_ctrl_assertions.sv
// Purpose: port checks on the mode block, attached by bind
// Assumes: clk 125 MHz, rst_n asynchronous and active low
// Notes: protocol pin changes are masked until four edges have passed
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_params.svh"
module mode_ctrl_assertions
  import mode_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic proto_second,
  input wire tel_s tel,
  input wire mode_e mode,
  input wire logic freset
);
  logic [3:0] pr_ff;
  logic pr_ok;
  logic dat;
  // the pin is unsynchronised, so only trust it once it has stood still
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pr_ff <= 4'h0;
    else
      pr_ff <= {pr_ff[2:0], proto_second};
  end
  assign pr_ok = (pr_ff == 4'hf) || (pr_ff == 4'h0);
  assign dat = tel.valid && tel.kind == TEL_DATA && pr_ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_freset_one_cycle: assert property (freset |=> !freset)
    else $error("factory reset pulse longer than one cycle");
  chk_no_opt_data: assert property (tel.valid |-> !tel.opt_data)
    else $error("optional data requested");
  chk_repeat_count: assert property (tel.valid |-> tel.repeats ==
    (tel.kind != TEL_DATA ? `REP_TEACH :
     mode == MODE_NORMAL ? `REP_NORMAL : `REP_SECURE))
    else $error("wrong repeat count");
  chk_reduced_normal: assert property (dat && !pr_ff[0] &&
    mode == MODE_NORMAL |-> tel.reduced && tel.length == `LEN_RED_NORMAL &&
    tel.exp_type == `TYPE_ROCKER &&
    (tel.frame_type inside {`TYPE_RED_PRESS, `TYPE_RED_RELEASE}))
    else $error("bad reduced normal frame");
  chk_reduced_secure: assert property (dat && !pr_ff[0] &&
    mode == MODE_SEC_IMPL |-> tel.reduced &&
    tel.frame_type == `TYPE_RED_SECURE && tel.exp_type == `TYPE_SECURE &&
    tel.exp_id_msb == `ID_EXT_MSB)
    else $error("bad reduced secure frame");
  chk_explicit_frame: assert property (dat && !pr_ff[0] &&
    mode == MODE_SEC_EXPL |-> !tel.reduced && tel.frame_type == `TYPE_SECURE)
    else $error("explicit counter sent a reduced frame");
  chk_header_normal: assert property (dat && pr_ff[0] &&
    mode == MODE_NORMAL |-> tel.header ==
    {`ADDR_CTL_ORIG32, `EXT_HDR_NONE, `TTYPE_ROCKER})
    else $error("bad normal header");
  chk_header_secure: assert property (tel.valid && pr_ok &&
    pr_ff[0] && mode != MODE_NORMAL |-> tel.header ==
    {`ADDR_CTL_ORIG32, `EXT_HDR_NONE, `TTYPE_SECURE})
    else $error("bad secure header");
  chk_teach_secure: assert property (tel.valid &&
    tel.kind != TEL_DATA |-> mode != MODE_NORMAL)
    else $error("teach telegram in normal mode");
  cov_freset: cover property (freset);
  cov_teach2: cover property (tel.valid && tel.kind == TEL_TEACH2);
  cov_second: cover property (dat && pr_ff[0]);
endmodule // mode_ctrl_assertions
bind mode_ctrl mode_ctrl_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .proto_second(proto_second), .tel(tel), .mode(mode), .freset(freset));
`default_nettype wire

// ### user_model.sv
// Purpose: user at the contacts and bow, plus a receiver that logs telegrams
// Assumes: tasks are called from the bench between clock edges
// Notes: contacts settle four cycles before each bow edge
`timescale 1ns/1ps
`default_nettype none
module user_model
  import mode_ctrl_pkg::*;
(
  input wire logic clk,
  input wire tel_s tel,
  output logic [3:0] contacts,
  output logic bow
);
  tel_s rx_q[$];
  int rx_total;
  initial begin
    contacts = 4'h0;
    bow = 1'b0;
    rx_total = 0;
  end
  // receiver samples mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (tel.valid === 1'b1) begin
      rx_q.push_back(tel);
      rx_total++;
    end
  end
  // chord stays put from before the bow edge until well after it
  task automatic act(input logic [3:0] c, input logic b);
    @(posedge clk);
    contacts <= c;
    repeat (4) @(posedge clk);
    bow <= b;
    repeat (8) @(posedge clk);
  endtask
  // n press and release cycles under one chord
  task automatic taps(input logic [3:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      act(c, 1'b1);
      act(c, 1'b0);
    end
  endtask
endmodule // user_model
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the mode block
// Assumes: the user model drives contacts and bow; ce dropped once
// Notes: frame fields are rebuilt here from the package codes
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_params.svh"
module testbench;
  import mode_ctrl_pkg::*;
  localparam logic [31:0] ID = 32'h00000001; // arbitrary value
  logic clk, rst_n, ce, proto_second, wr, rd, bow, unlocked, freset;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] contacts;
  tel_s tel, t;
  mode_e mode;
  int err_total, checks_done, cyc, fr_cnt, nrx;
  mode_ctrl #(.TX_ID(ID)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .a_upper(contacts[3]), .a_lower(contacts[2]), .b_upper(contacts[1]),
    .b_lower(contacts[0]), .bow(bow), .proto_second(proto_second),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tel(tel), .mode(mode), .unlocked(unlocked), .freset(freset));
  user_model um (.clk(clk), .tel(tel), .contacts(contacts), .bow(bow));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard; the tests need well under a tenth of this
  always @(negedge clk) begin
    cyc++;
    if (freset === 1'b1)
      fr_cnt++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  function automatic logic [3:0] ck4(input logic [47:0] x);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 12; i++)
      s = s + x[4*i +: 4];
    return s;
  endfunction
  task automatic pop();
    if (um.rx_q.size() == 0)
      chk("telegram", 32'h0, 32'h1);
    else
      t = um.rx_q.pop_front();
  endtask
  // plain tap in normal mode, first protocol
  task automatic tap_data(input logic [3:0] c);
    um.rx_q.delete();
    for (int b = 1; b >= 0; b--) begin
      um.act(c, b[0]);
      pop();
      chk("type", t.frame_type,
          b ? `TYPE_RED_PRESS : `TYPE_RED_RELEASE);
      chk("length", t.length, `LEN_RED_NORMAL);
      chk("check", t.check, ck4({t.frame_type, t.data, ID}));
      chk("repeats", t.repeats, `REP_NORMAL);
    end
  endtask
  task automatic tap_hdr(input logic [7:0] e);
    um.rx_q.delete();
    um.taps(4'h0, 1);
    pop();
    chk("header", t.header, e);
  endtask
  task automatic teach_chk(input logic rk);
    int n1 = 0;
    int n2 = 0;
    foreach (um.rx_q[i]) begin
      n1 += (um.rx_q[i].kind == TEL_TEACH1);
      n2 += (um.rx_q[i].kind == TEL_TEACH2);
      if (um.rx_q[i].kind != TEL_DATA)
        chk("rocker", um.rx_q[i].rocker, rk);
    end
    chk("teach one", n1, 1);
    chk("teach two", n2, 1);
  endtask
  // second release drops the chord on purpose
  task automatic dbl(input logic [3:0] c);
    um.rx_q.delete();
    um.act(c, 1'b1);
    um.act(c, 1'b0);
    um.act(c, 1'b1);
    um.act(4'h0, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    proto_second = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    void'($urandom(72));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("unlocked", unlocked, 1'b0);
    rchk("counter", `OFS_COUNTER, 32'h0);
    wr_reg(`OFS_CFG_BASE, 32'h1);
    wr_reg(`OFS_PIN_TRY, `PIN_DEFAULT ^ 32'h1);
    #1 chk("unlocked", unlocked, 1'b0);
    wr_reg(`OFS_PIN_TRY, `PIN_DEFAULT);
    #1 chk("unlocked", unlocked, 1'b1);
    rchk("locked write", `OFS_CFG_BASE, 32'h0);
    v = $urandom();
    wr_reg(`OFS_CFG_BASE + 12'h8, v);
    rchk("page", `OFS_CFG_BASE + 12'hb, v);
    rchk("unmapped", 12'hffc, 32'h0);
    wr_reg(`OFS_USER_BASE + 12'h4, ~v);
    wr_reg(`OFS_LOCK, 32'h0);
    rchk("relocked", `OFS_CFG_BASE + 12'h8, 32'h0);
    // a frozen block must neither see a tap nor send for it
    nrx = um.rx_total;
    ce <= 1'b0;
    um.taps(4'h0, 1);
    ce <= 1'b1;
    chk("frozen", um.rx_total, nrx);
    tap_data(4'h0);
    for (int i = 0; i < 6; i++)
      tap_data(4'h1 << ($urandom() % 4));
    um.taps(4'b1100, 1);
    um.taps(4'b1010, 2);
    chk("mode", mode, MODE_NORMAL);
    dbl(4'b1100);
    chk("mode", mode, MODE_SEC_IMPL);
    teach_chk(1'b0);
    um.taps(4'h0, 1);
    for (int i = 0; i < 4; i++) begin
      um.taps(4'hf, 1);
      chk("mode", mode, MODE_NORMAL);
      dbl(4'hf ^ (4'h1 << i));
      chk("mode", mode, MODE_SEC_EXPL);
      teach_chk(i > 1);
    end
    um.taps(4'h0, 1);
    um.rx_q.delete();
    um.taps(4'b0111, 1);
    teach_chk(1'b1);
    proto_second <= 1'b1;
    tap_hdr({`ADDR_CTL_ORIG32, `EXT_HDR_NONE, `TTYPE_SECURE});
    um.taps(4'hf, 1);
    tap_hdr({`ADDR_CTL_ORIG32, `EXT_HDR_NONE, `TTYPE_ROCKER});
    proto_second <= 1'b0;
    wr_reg(`OFS_PIN_TRY, `PIN_DEFAULT);
    wr_reg(`OFS_CFG_BASE, v);
    wr_reg(`OFS_PIN_NEW, 32'h00001234);
    fr_cnt = 0;
    um.taps(4'hf, 7);
    chk("freset", fr_cnt, 1);
    wr_reg(`OFS_PIN_TRY, `PIN_DEFAULT);
    #1 chk("default pin", unlocked, 1'b1);
    rchk("cfg cleared", `OFS_CFG_BASE, 32'h0);
    rchk("user kept", `OFS_USER_BASE + 12'h4, ~v);
    rchk("counter", `OFS_COUNTER, um.rx_total);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
